// ==== src/charger_regs_map.svh ====
// Register offsets, field positions, reset values and timing counts of the charger register bank
`ifndef CHARGER_REGS_MAP_SVH
`define CHARGER_REGS_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_RAIL_CFG      8'h07
`define OFS_SHIP_CFG      8'h08
`define OFS_ADDR_CFG      8'h09
`define OFS_CHG_STATUS    8'h0d
`define OFS_FAULT_STATUS  8'h0e

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_RAIL_CFG      8'h39
`define RST_SHIP_CFG      8'h06
`define RST_ADDR_CFG      8'h25

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RAIL_CODE_MSB     3
`define SHIP_DGL_MSB      7
`define SHIP_DGL_LSB      6
`define COOL_CV_EN_BIT    3
`define HOT_THR_MSB       2
`define HOT_THR_LSB       1
`define COOL_THR_BIT      0
`define BUS_ADDR_MSB      7
`define BUS_ADDR_LSB      5
`define ZONE_CC_MSB       3
`define ZONE_CC_LSB       2
`define ZONE_CV_MSB       1
`define ZONE_CV_LSB       0
`define BUS_ADDR_PREFIX   4'h2
`define TEMP_ZONE_CODE    2'h3

// ------------------------------------------------------------
// Analog setting figures
// ------------------------------------------------------------
`define RAIL_BASE_MV      4200
`define RAIL_STEP_MV      50
`define CV_STEP_MV        100
`define HOT_THR_45C       13'd4475
`define HOT_THR_50C       13'd4125
`define HOT_THR_55C       13'd3775
`define HOT_THR_60C       13'd3450
`define COOL_THR_10C      13'd6825
`define COOL_THR_15C      13'd6525

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_FREQ_KHZ      100000
`define SHIP_DGL_BASE_MS  1000
`define SHIP_DGL_BASE_CYC (`SHIP_DGL_BASE_MS * `CLK_FREQ_KHZ)

`endif

// ==== src/charger_regs_pkg.sv ====
// Types shared by the charger register bank
package charger_regs_pkg;

    // Gray codes along the write path, then the read path
    typedef enum logic [3:0] {
        BUS_IDLE    = 4'h0,
        BUS_ADDR    = 4'h1,
        BUS_ADDR_AK = 4'h3,
        BUS_PTR     = 4'h2,
        BUS_PTR_AK  = 4'h6,
        BUS_WR      = 4'h7,
        BUS_WR_AK   = 4'h5,
        BUS_RD      = 4'h4,
        BUS_RD_AK   = 4'hc
    } bus_state_t;

    typedef struct packed {
        bus_state_t  state;
        logic [7:0]  shift;
        logic [3:0]  bitcnt;
        logic        rd_mode;
        logic [7:0]  ptr;
        logic        host_ack;
        logic        sda_oe;
        logic        sda_out;
        logic        scl_d;
        logic        sda_d;
        logic [7:0]  rail_cfg;
        logic [7:0]  ship_cfg;
        logic [7:0]  addr_cfg;
        logic        wdt_flag;
        logic [3:0]  faults;
        logic [29:0] ship_cnt;
        logic        ship_enter;
        logic [12:0] sys_rail_mv;
        logic [12:0] hot_thr;
        logic [12:0] cool_thr;
        logic [1:0]  cc_shift;
        logic [8:0]  cv_derate_mv;
    } bank_state_t;

endpackage

// ==== src/sync_if.sv ====
// Raw and synchronised copies of a group of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
interface sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] q;
    modport syncer (input raw, output q);
    modport user   (output raw, input q);
endinterface
`default_nettype wire

// ==== src/level_sync.sv ====
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sync_if.syncer    port
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] stable_ff;

    // First stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff   <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff   <= port.raw;
            stable_ff <= meta_ff;
        end
    end

    assign port.q = stable_ff;
endmodule
`default_nettype wire

// ==== src/charger_config_status_regs.sv ====
// Charger configuration and status register bank behind a two-wire serial slave
`timescale 1ns/100ps
`default_nettype none
`include "charger_regs_map.svh"
module charger_config_status_regs
    import charger_regs_pkg::*;
#(
    parameter int SHIP_DGL_BASE_CYCLES = `SHIP_DGL_BASE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        ship_req,
    input  wire logic        wdt_expired,
    input  wire logic        tj_reg_active,
    input  wire logic [1:0]  chg_stat,
    input  wire logic        vin_dpm,
    input  wire logic        input_source_fault,
    input  wire logic        thermal_shutdown_flag,
    input  wire logic        battery_overvoltage_flag,
    input  wire logic        safety_timer_expired,
    input  wire logic [1:0]  battery_temp_state,
    input  wire logic        battery_cool,
    output logic [12:0]      sys_rail_mv,
    output logic             ship_enter,
    output logic [12:0]      hot_thr_pct,
    output logic [12:0]      cool_thr_pct,
    output logic [1:0]       zone_current_shift,
    output logic [8:0]       zone_voltage_drop_mv
);

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_sync_n;

    sync_if #(.W(1)) rst_if ();
    assign rst_if.raw = 1'b1;
    level_sync #(.W(1)) u_rst_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (rst_if)
    );
    assign rst_sync_n = rst_if.q[0];

    sync_if #(.W(15)) pin_if ();
    assign pin_if.raw = {scl_in, sda_in, ship_req, wdt_expired, tj_reg_active, chg_stat,
                         vin_dpm, input_source_fault, thermal_shutdown_flag,
                         battery_overvoltage_flag, safety_timer_expired,
                         battery_temp_state, battery_cool};
    level_sync #(.W(15)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .port  (pin_if)
    );

    logic       scl_s;
    logic       sda_s;
    logic       ship_req_s;
    logic       wdt_s;
    logic       tj_s;
    logic [1:0] chg_s;
    logic       dpm_s;
    logic [3:0] fault_evt_s;
    logic [1:0] temp_s;
    logic       cool_s;

    assign {scl_s, sda_s, ship_req_s, wdt_s, tj_s, chg_s, dpm_s, fault_evt_s,
            temp_s, cool_s} = pin_if.q;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    localparam bank_state_t ST_RESET = '{
        state: BUS_IDLE, shift: 8'h00, bitcnt: 4'h0, rd_mode: 1'b0, ptr: 8'h00,
        host_ack: 1'b0, sda_oe: 1'b0, sda_out: 1'b0, scl_d: 1'b0, sda_d: 1'b0,
        rail_cfg: `RST_RAIL_CFG, ship_cfg: `RST_SHIP_CFG, addr_cfg: `RST_ADDR_CFG,
        wdt_flag: 1'b0, faults: 4'h0, ship_cnt: 30'h0, ship_enter: 1'b0,
        sys_rail_mv: 13'h122a, hot_thr: `HOT_THR_45C, cool_thr: `COOL_THR_10C,
        cc_shift: 2'h0, cv_derate_mv: 9'h000
    };

    bank_state_t st;
    bank_state_t nxt_st;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= ST_RESET;
        end else begin
            st <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------
    function automatic logic [7:0] read_byte(input bank_state_t s, input logic [7:0] ofs,
                                             input logic [1:0] chg, input logic dpm,
                                             input logic tj, input logic [1:0] temp);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            `OFS_RAIL_CFG:     v = s.rail_cfg;
            `OFS_SHIP_CFG:     v = s.ship_cfg;
            `OFS_ADDR_CFG:     v = s.addr_cfg;
            `OFS_CHG_STATUS:   v = {s.wdt_flag, 2'h0, chg, dpm, 1'b0, tj};
            `OFS_FAULT_STATUS: v = {2'h0, s.faults, temp};
            default:           v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       rd_chg_clr;
    logic       rd_flt_clr;
    logic [6:0] own_addr;

    assign scl_rise  = scl_s & ~st.scl_d;
    assign scl_fall  = ~scl_s & st.scl_d;
    assign bus_start = scl_s & st.scl_d & st.sda_d & ~sda_s;
    assign bus_stop  = scl_s & st.scl_d & ~st.sda_d & sda_s;
    assign own_addr  = {`BUS_ADDR_PREFIX, st.addr_cfg[`BUS_ADDR_MSB:`BUS_ADDR_LSB]};

    always_comb begin
        logic [7:0]  tx;
        logic [29:0] ship_target;
        logic        zone;
        logic        load_rd;
        tx          = 8'h00;
        ship_target = 30'h0;
        zone        = 1'b0;
        load_rd     = 1'b0;
        rd_chg_clr  = 1'b0;
        rd_flt_clr  = 1'b0;
        nxt_st      = st;
        nxt_st.scl_d   = scl_s;
        nxt_st.sda_d   = sda_s;
        nxt_st.sda_out = 1'b0;

        if (bus_start) begin
            nxt_st.state  = BUS_ADDR;
            nxt_st.bitcnt = 4'h0;
            nxt_st.sda_oe = 1'b0;
        end else if (bus_stop) begin
            nxt_st.state  = BUS_IDLE;
            nxt_st.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (st.state)
                BUS_ADDR, BUS_PTR, BUS_WR: begin
                    nxt_st.shift  = {st.shift[6:0], sda_s};
                    nxt_st.bitcnt = st.bitcnt + 4'h1;
                end
                BUS_RD: begin
                    nxt_st.bitcnt = st.bitcnt + 4'h1;
                end
                BUS_RD_AK: begin
                    nxt_st.host_ack = ~sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st.state)
                BUS_ADDR: begin
                    if (st.bitcnt == 4'h8) begin
                        if (st.shift[7:1] == own_addr) begin
                            nxt_st.state   = BUS_ADDR_AK;
                            nxt_st.rd_mode = st.shift[0];
                            nxt_st.sda_oe  = 1'b1;
                        end else begin
                            nxt_st.state = BUS_IDLE;
                        end
                    end
                end
                BUS_ADDR_AK: begin
                    nxt_st.bitcnt = 4'h0;
                    if (st.rd_mode) begin
                        load_rd = 1'b1;
                    end else begin
                        nxt_st.state  = BUS_PTR;
                        nxt_st.sda_oe = 1'b0;
                    end
                end
                BUS_PTR: begin
                    if (st.bitcnt == 4'h8) begin
                        nxt_st.ptr    = st.shift;
                        nxt_st.state  = BUS_PTR_AK;
                        nxt_st.sda_oe = 1'b1;
                    end
                end
                BUS_PTR_AK, BUS_WR_AK: begin
                    nxt_st.state  = BUS_WR;
                    nxt_st.bitcnt = 4'h0;
                    nxt_st.sda_oe = 1'b0;
                end
                BUS_WR: begin
                    if (st.bitcnt == 4'h8) begin
                        // Unmapped and read-only offsets take the byte and drop it
                        case (st.ptr)
                            `OFS_RAIL_CFG: nxt_st.rail_cfg = st.shift;
                            `OFS_SHIP_CFG: nxt_st.ship_cfg = st.shift;
                            `OFS_ADDR_CFG: nxt_st.addr_cfg = st.shift;
                            default: begin
                            end
                        endcase
                        nxt_st.ptr    = st.ptr + 8'h01;
                        nxt_st.state  = BUS_WR_AK;
                        nxt_st.sda_oe = 1'b1;
                    end
                end
                BUS_RD: begin
                    if (st.bitcnt == 4'h8) begin
                        nxt_st.state  = BUS_RD_AK;
                        nxt_st.sda_oe = 1'b0;
                    end else begin
                        nxt_st.shift  = {st.shift[6:0], 1'b0};
                        nxt_st.sda_oe = ~st.shift[6];
                    end
                end
                BUS_RD_AK: begin
                    if (st.host_ack) begin
                        nxt_st.bitcnt = 4'h0;
                        load_rd       = 1'b1;
                    end else begin
                        nxt_st.state = BUS_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read side effect happens when the byte is committed to the shifter
        if (load_rd) begin
            tx             = read_byte(st, st.ptr, chg_s, dpm_s, tj_s, temp_s);
            nxt_st.state   = BUS_RD;
            nxt_st.shift   = tx;
            nxt_st.sda_oe  = ~tx[7];
            nxt_st.ptr     = st.ptr + 8'h01;
            rd_chg_clr     = (st.ptr == `OFS_CHG_STATUS);
            rd_flt_clr     = (st.ptr == `OFS_FAULT_STATUS);
        end

        // Set wins over read clear, so an event on the read edge is kept
        nxt_st.wdt_flag = (st.wdt_flag & ~rd_chg_clr) | wdt_s;
        nxt_st.faults   = (st.faults & {4{~rd_flt_clr}}) | fault_evt_s;

        // Ship entry waits for an unbroken request of the selected length
        ship_target = 30'(SHIP_DGL_BASE_CYCLES) <<
                      st.ship_cfg[`SHIP_DGL_MSB:`SHIP_DGL_LSB];
        if (!ship_req_s) begin
            nxt_st.ship_cnt   = 30'h0;
            nxt_st.ship_enter = 1'b0;
        end else if (st.ship_cnt >= ship_target - 30'h1) begin
            nxt_st.ship_enter = 1'b1;
        end else begin
            nxt_st.ship_cnt = st.ship_cnt + 30'h1;
        end

        nxt_st.sys_rail_mv = 13'(`RAIL_BASE_MV +
                             `RAIL_STEP_MV * st.rail_cfg[`RAIL_CODE_MSB:0]);

        case (st.ship_cfg[`HOT_THR_MSB:`HOT_THR_LSB])
            2'h3:    nxt_st.hot_thr = `HOT_THR_45C;
            2'h2:    nxt_st.hot_thr = `HOT_THR_50C;
            2'h1:    nxt_st.hot_thr = `HOT_THR_55C;
            default: nxt_st.hot_thr = `HOT_THR_60C;
        endcase
        nxt_st.cool_thr = st.ship_cfg[`COOL_THR_BIT] ? `COOL_THR_15C : `COOL_THR_10C;

        // Warm zone always derates voltage; cool zone only when enabled
        zone = (temp_s == `TEMP_ZONE_CODE);
        nxt_st.cc_shift = zone ? st.addr_cfg[`ZONE_CC_MSB:`ZONE_CC_LSB] : 2'h0;
        if (zone && (!cool_s || st.ship_cfg[`COOL_CV_EN_BIT])) begin
            nxt_st.cv_derate_mv = 9'(`CV_STEP_MV *
                                  st.addr_cfg[`ZONE_CV_MSB:`ZONE_CV_LSB]);
        end else begin
            nxt_st.cv_derate_mv = 9'h000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_out              = st.sda_out;
    assign sda_oe               = st.sda_oe;
    assign sys_rail_mv          = st.sys_rail_mv;
    assign ship_enter           = st.ship_enter;
    assign hot_thr_pct          = st.hot_thr;
    assign cool_thr_pct         = st.cool_thr;
    assign zone_current_shift   = st.cc_shift;
    assign zone_voltage_drop_mv = st.cv_derate_mv;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_cool_zone_locked;
        temp_s == `TEMP_ZONE_CODE && cool_s && !st.ship_cfg[`COOL_CV_EN_BIT];
    endsequence

    sequence s_flt_idle;
        !rd_flt_clr && fault_evt_s == 4'h0;
    endsequence

    property p_rail_mv;
        @(posedge clk) disable iff (!rst_sync_n)
        ##1 sys_rail_mv == 13'(`RAIL_BASE_MV + `RAIL_STEP_MV * $past(st.rail_cfg[3:0]));
    endproperty
    a_rail_mv: assert property (p_rail_mv) else $error("rail target mismatch");
    property p_ship_gap;
        @(posedge clk) disable iff (!rst_sync_n)
        !ship_req_s |=> !ship_enter && st.ship_cnt == 30'h0;
    endproperty
    a_ship_gap: assert property (p_ship_gap) else $error("ship entry without request");
    property p_ship_rise;
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(ship_enter) |-> $past(st.ship_cnt) ==
            (30'(SHIP_DGL_BASE_CYCLES) << $past(st.ship_cfg[7:6])) - 30'h1;
    endproperty
    a_ship_rise: assert property (p_ship_rise) else $error("ship entry early");
    property p_cool_cv_off;
        @(posedge clk) disable iff (!rst_sync_n)
        s_cool_zone_locked |=> zone_voltage_drop_mv == 9'h000;
    endproperty
    a_cool_cv_off: assert property (p_cool_cv_off) else $error("cool derate while disabled");
    property p_hot_thr;
        @(posedge clk) disable iff (!rst_sync_n)
        st.ship_cfg[2:1] == 2'h3 ##1 st.ship_cfg[2:1] == 2'h3 |-> hot_thr_pct == `HOT_THR_45C;
    endproperty
    a_hot_thr: assert property (p_hot_thr) else $error("hot threshold mismatch");
    property p_cool_thr;
        @(posedge clk) disable iff (!rst_sync_n)
        ##1 cool_thr_pct == ($past(st.ship_cfg[0]) ? `COOL_THR_15C : `COOL_THR_10C);
    endproperty
    a_cool_thr: assert property (p_cool_thr) else $error("cool threshold mismatch");
    property p_addr_ack;
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(st.state == BUS_ADDR_AK) |-> st.shift[7:1] == own_addr && sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("ack of foreign address");
    property p_zone_cc;
        @(posedge clk) disable iff (!rst_sync_n)
        temp_s != `TEMP_ZONE_CODE |=> zone_current_shift == 2'h0;
    endproperty
    a_zone_cc: assert property (p_zone_cc) else $error("current scaled outside zone");
    property p_wdt_set;
        @(posedge clk) disable iff (!rst_sync_n)
        wdt_s |=> st.wdt_flag;
    endproperty
    a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag lost");
    property p_flt_hold;
        @(posedge clk) disable iff (!rst_sync_n)
        s_flt_idle |=> st.faults == $past(st.faults);
    endproperty
    a_flt_hold: assert property (p_flt_hold) else $error("fault flag changed unread");
    property p_flt_set;
        @(posedge clk) disable iff (!rst_sync_n)
        fault_evt_s != 4'h0 |=> (st.faults & $past(fault_evt_s)) == $past(fault_evt_s);
    endproperty
    a_flt_set: assert property (p_flt_set) else $error("fault not latched");

endmodule
`default_nettype wire

// ==== verif/bus_host.sv ====
// Host bus master model: drives the bus clock and data, data line pulled up
`timescale 1ns/100ps
`default_nettype none
module bus_host (
    input  wire logic clk,
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // One quarter of the 80 ns bus period per step
    task automatic pin(input logic c, input logic v);
        scl = c;
        sda_drv = v;
        repeat (2) @(negedge clk);
    endtask
    // Start is cond(1,0), stop is cond(0,1)
    task automatic cond(input logic a, input logic b);
        pin(1'b0, sda_drv);
        pin(1'b0, a);
        pin(1'b1, a);
        pin(1'b1, b);
    endtask
    // Data moves one step after the clock falls, never with it
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            pin(1'b0, sda_drv);
            pin(1'b0, tx[i]);
            pin(1'b1, tx[i]);
            pin(1'b1, tx[i]);
            rx[i] = sda_line;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
                      output logic ok);
        logic [8:0] ra, rp, rv;
        cond(1'b1, 1'b0);
        xfer({a, 2'b01}, ra);
        xfer({p, 1'b1}, rp);
        xfer({v, 1'b1}, rv);
        cond(1'b0, 1'b1);
        ok = ~(ra[0] | rp[0] | rv[0]);
    endtask
    // Host ends every read with a not-acknowledge
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] v);
        logic [8:0] rx;
        cond(1'b1, 1'b0);
        xfer({a, 2'b01}, rx);
        xfer({p, 1'b1}, rx);
        cond(1'b1, 1'b0);
        xfer({a, 2'b11}, rx);
        xfer(9'h1ff, rx);
        cond(1'b0, 1'b1);
        v = rx[8:1];
    endtask
    // Two bytes from one pointer: acknowledge the first, refuse the second
    task automatic rd2(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v);
        logic [8:0] rx;
        logic [8:0] ry;
        cond(1'b1, 1'b0);
        xfer({a, 2'b01}, rx);
        xfer({p, 1'b1}, rx);
        cond(1'b1, 1'b0);
        xfer({a, 2'b11}, rx);
        xfer(9'h1fe, rx);
        xfer(9'h1ff, ry);
        cond(1'b0, 1'b1);
        v = {rx[8:1], ry[8:1]};
    endtask
    // Two data bytes after one pointer, the second lands at pointer plus one
    task automatic wr2(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
                       output logic ok);
        logic [8:0] ra, rp, rv, rw;
        cond(1'b1, 1'b0);
        xfer({a, 2'b01}, ra);
        xfer({p, 1'b1}, rp);
        xfer({v[15:8], 1'b1}, rv);
        xfer({v[7:0], 1'b1}, rw);
        cond(1'b0, 1'b1);
        ok = ~(ra[0] | rp[0] | rv[0] | rw[0]);
    endtask
endmodule
`default_nettype wire

// ==== verif/charger_config_status_regs_tb.sv ====
// Self-checking bench for the charger register bank
`timescale 1ns/100ps
`default_nettype none
module charger_config_status_regs_tb;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             ship_req = 1'b0, wdt = 1'b0, tj = 1'b0, dpm = 1'b0, cool = 1'b0;
    logic [1:0]       chg = 2'h0, temp = 2'h0;
    logic [3:0]       flt = 4'h0;
    logic [6:0]       addr = 7'h11;
    logic [7:0]       d;
    logic             ok;
    int               bad_count = 0, check_count = 0;
    wire logic        scl, sda_drv, sda_oe, sda_out, ship_enter;
    wire logic [12:0] rail, hot, cthr;
    wire logic [8:0]  drop;
    wire logic [1:0]  shift;
    wire logic        sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;
    initial forever #5 clk = ~clk;
    charger_config_status_regs #(.SHIP_DGL_BASE_CYCLES(20)) u_dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .ship_req(ship_req), .wdt_expired(wdt), .tj_reg_active(tj),
        .chg_stat(chg), .vin_dpm(dpm), .input_source_fault(flt[3]),
        .thermal_shutdown_flag(flt[2]), .battery_overvoltage_flag(flt[1]),
        .safety_timer_expired(flt[0]), .battery_temp_state(temp), .battery_cool(cool),
        .sys_rail_mv(rail), .ship_enter(ship_enter), .hot_thr_pct(hot),
        .cool_thr_pct(cthr), .zone_current_shift(shift), .zone_voltage_drop_mv(drop));
    bus_host u_host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [7:0] p, input logic [7:0] v);
        u_host.wr(addr, p, v, ok);
        chk("ack", 16'h1, ok);
        repeat (4) @(negedge clk);
    endtask
    task automatic r(input logic [7:0] p, input logic [7:0] e);
        u_host.rd(addr, p, d);
        chk("rdata", e, d);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_reset();
        logic [15:0] pair;
        u_host.rd2(addr, 8'h08, pair);
        chk("pair", 16'h0625, pair);
        r(8'h07, 8'h39);
        r(8'h08, 8'h06);
        r(8'h09, 8'h25);
        r(8'h20, 8'h00);
        chk("rail", 4650, rail);
        chk("hot", 4475, hot);
        chk("cool", 6825, cthr);
        u_host.wr2(addr, 8'h07, 16'h3a00, ok);
        repeat (4) @(negedge clk);
        chk("pair ack", 16'h1, ok);
        chk("rail", 4700, rail);
        chk("hot", 3450, hot);
    endtask
    task automatic t_rail();
        for (int k = 0; k < 16; k++) begin
            w(8'h07, 8'(48 + k));
            chk("rail", 4200 + 50 * k, rail);
        end
    endtask
    task automatic t_temp();
        int ht[4] = '{3450, 3775, 4125, 4475};
        for (int k = 0; k < 4; k++) begin
            w(8'h08, 8'(k * 2 + k % 2));
            chk("hot", ht[k], hot);
            chk("cool", (k % 2) ? 6525 : 6825, cthr);
        end
    endtask
    task automatic t_zone();
        temp = 2'h3;
        for (int k = 0; k < 4; k++) begin
            w(8'h09, 8'(32 + k * 5));
            chk("shift", k, shift);
            chk("drop", 100 * k, drop);
        end
        cool = 1'b1;
        w(8'h08, 8'h06);
        chk("drop", 0, drop);
        w(8'h08, 8'h0e);
        chk("drop", 300, drop);
        temp = 2'h0;
    endtask
    // Base cut to 20 cycles, code 01 doubles it; the synchroniser adds two more
    task automatic t_ship();
        w(8'h08, 8'h46);
        ship_req = 1'b1;
        repeat (41) @(negedge clk);
        chk("ship", 0, ship_enter);
        repeat (1) @(negedge clk);
        chk("ship", 1, ship_enter);
        ship_req = 1'b0;
        repeat (5) @(negedge clk);
        chk("ship", 0, ship_enter);
    endtask
    task automatic t_fault();
        temp = 2'h1;
        tj = 1'b1;
        chg = 2'h2;
        dpm = 1'b1;
        wdt = 1'b1;
        for (int k = 0; k < 4; k++) begin
            flt = 4'h1 << k;
            repeat (5) @(negedge clk);
            flt = 4'h0;
            repeat (5) @(negedge clk);
            r(8'h0e, 8'h01 | (8'h04 << k));
            r(8'h0e, 8'h01);
        end
        wdt = 1'b0;
        r(8'h0d, 8'h95);
        r(8'h0d, 8'h15);
    endtask
    task automatic t_addr();
        w(8'h09, 8'ha5);
        addr = 7'h15;
        r(8'h09, 8'ha5);
        u_host.wr(7'h11, 8'h09, 8'h25, ok);
        chk("old address ack", 0, ok);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        t_reset();
        t_rail();
        t_temp();
        t_zone();
        t_ship();
        t_fault();
        t_addr();
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
